// ===== inc/drc_map.svh
// constants for the dram access and refresh controller
// assumes a 25 MHz system clock; included by the design files
`ifndef DRC_MAP_SVH
`define DRC_MAP_SVH

`define DRC_CLK_PERIOD_NS      40
`define DRC_ROW_MAX            8'hff
`define DRC_ROW_RESET          8'h00
// refresh interval per row, in ns, one entry per rate; fast serves three of the four lookup slots
`define DRC_INTERVAL_FAST_NS   15000
`define DRC_INTERVAL_SLOW_NS   30000
`define DRC_INTERVAL_FAST_CYC  ((`DRC_INTERVAL_FAST_NS) / (`DRC_CLK_PERIOD_NS))
`define DRC_INTERVAL_SLOW_CYC  ((`DRC_INTERVAL_SLOW_NS) / (`DRC_CLK_PERIOD_NS))
// row strobe low time of a refresh cycle, in clocks
`define DRC_REF_RAS_CYC        3
`define DRC_REF_RAS_LONG_CYC   4
`define DRC_TIMER_RESET        10'h000

`endif

// ===== inc/drc_pkg.sv
// types shared by the dram controller files
// assumes drc_map.svh sits on the include path
package drc_pkg;

    typedef enum logic [1:0] {
        DRC_DISTRIBUTED,
        DRC_TRANSPARENT,
        DRC_CYCLE_STEAL
    } drc_mode_t;

    typedef struct packed {
        drc_mode_t  mode;
        logic [9:0] interval;
        logic [2:0] ras_cycles;
    } drc_cfg_t;

    typedef struct packed {
        logic       wait_timing_strap;
        logic       rate_strap_1;
        logic       rate_strap_0;
    } drc_straps_t;

    typedef struct packed {
        logic [7:0] row_addr_in;
        logic [7:0] col_addr_in;
        logic       chip_select_n;
        logic       bank_select;
    } drc_latch_t;

endpackage

// ===== design/drc_strap_decode.sv
// strap lookup: turns the three strap pins into refresh mode, rate, timing
// assumes straps are static after power up
`timescale 1ns/1ns
`default_nettype none
`include "drc_map.svh"

module drc_strap_decode
    import drc_pkg::*;
(
    input  wire drc_straps_t straps,
    output drc_cfg_t         cfg
);

    // mode from the two rate straps, timing from the wait strap
    always_comb begin
        cfg = '0;
        unique case ({straps.rate_strap_1, straps.rate_strap_0})
            2'b00: begin
                cfg.mode     = DRC_DISTRIBUTED;
                cfg.interval = 10'(`DRC_INTERVAL_FAST_CYC);
            end
            2'b01: begin
                cfg.mode     = DRC_DISTRIBUTED;
                cfg.interval = 10'(`DRC_INTERVAL_SLOW_CYC);
            end
            2'b10: begin
                cfg.mode     = DRC_TRANSPARENT;
                cfg.interval = 10'(`DRC_INTERVAL_FAST_CYC);
            end
            2'b11: begin
                cfg.mode     = DRC_CYCLE_STEAL;
                cfg.interval = 10'(`DRC_INTERVAL_FAST_CYC);
            end
        endcase
        cfg.ras_cycles = straps.wait_timing_strap ?
                         3'(`DRC_REF_RAS_LONG_CYC) : 3'(`DRC_REF_RAS_CYC);
    end

endmodule // drc_strap_decode
`default_nettype wire

// ===== design/drc_refresh_timer.sv
// refresh interval timer counted in system clocks
// assumes cfg from the strap decoder; restart clears the count
`timescale 1ns/1ns
`default_nettype none
`include "drc_map.svh"

module drc_refresh_timer
    import drc_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic restart,
    input  wire logic [9:0] interval,
    output logic      expired
);

    logic [9:0] count_reg;
    logic [9:0] count_next;

    always_comb begin
        if (restart) begin
            count_next = `DRC_TIMER_RESET;
        end else if (count_reg >= interval - 10'd1) begin
            count_next = count_reg;
        end else begin
            count_next = count_reg + 10'd1;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            count_reg <= `DRC_TIMER_RESET;
        end else begin
            count_reg <= count_next;
        end
    end

    assign expired = (count_reg >= interval - 10'd1);

endmodule // drc_refresh_timer
`default_nettype wire

// ===== design/drc_controller.sv
// dram access and refresh controller: address mux, strobes, refresh
// assumes all inputs synchronous to sys_clk; refresh line open drain
`timescale 1ns/1ns
`default_nettype none
`include "drc_map.svh"

// What this block does
// - memory address comes from sixteen latched address bits, row/col halves
// - row address drives the memory address during the access row phase
// - eight-bit row counter supplies the address on every refresh
// - access and refresh never drive the strobes together
// - latch strobe captures address, chip select and bank select
// - access starts on latch strobe fall only when the chip select input pin is low
// - chip select sampled at trailing edge of latch strobe
// - a selected access drives only the bank-selected row strobe
// - read or write control low switches to column, asserts column strobe
// - first rising latch, read or write edge ends the access
// - outside low edge on refresh line starts refresh, resets timer
// - timer expiry pulls refresh line low and resets timer
// - refresh line held low until refresh row address is out
// - refresh drives both row strobes regardless of bank select
// - cycle-steal mode holds ready low during refresh
// - wait strap high adds one wait state to every memory cycle
// - straps choose refresh mode, rate and timing
// - all refresh timing counts system clocks only
module drc_controller
    import drc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic [7:0]  row_addr_in,
    input  wire logic [7:0]  col_addr_in,
    input  wire logic        addr_latch_en,
    input  wire logic        chip_select_n,
    input  wire logic        bank_select,
    input  wire logic        read_access_strobe_n,
    input  wire logic        write_access_strobe_n,
    input  wire logic        refresh_request_n_in,
    output logic             refresh_request_n_out,
    output logic             refresh_request_n_oe,
    input  wire drc_straps_t straps,
    output logic [7:0]       mem_addr_out,
    output logic [1:0]       row_strobe_bank_n,
    output logic             col_strobe_n,
    output logic             ready
);

    typedef enum logic [2:0] {
        DRC_IDLE,
        DRC_ROW,
        DRC_COL,
        DRC_REF_ADDR,
        DRC_REF_RAS
    } drc_state_t;

    drc_cfg_t    cfg;
    logic        timer_expired;
    logic        timer_restart;

    drc_state_t  state_reg, state_next;
    drc_latch_t  latch_reg, latch_next;
    logic [7:0]  row_cnt_reg, row_cnt_next;
    logic [2:0]  ras_cnt_reg, ras_cnt_next;
    logic        pend_reg, pend_next;
    logic        drive_req_reg, drive_req_next;
    logic        ale_d_reg, rd_d_reg, wr_d_reg, req_d_reg;
    logic        wait_reg, wait_next;
    logic [7:0]  addr_reg, addr_next;
    logic [1:0]  ras_reg, ras_next;
    logic        cas_reg, cas_next;

    logic ale_rise, ale_fall, rd_rise, wr_rise, req_fall, col_req, end_edge;

    drc_strap_decode u_decode (
        .straps (straps),
        .cfg    (cfg)
    );

    drc_refresh_timer u_timer (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .restart  (timer_restart),
        .interval (cfg.interval),
        .expired  (timer_expired)
    );

    // edge detection against last cycle's pin levels
    assign ale_rise = addr_latch_en && !ale_d_reg;
    assign ale_fall = !addr_latch_en && ale_d_reg;
    assign rd_rise  = read_access_strobe_n && !rd_d_reg;
    assign wr_rise  = write_access_strobe_n && !wr_d_reg;
    assign req_fall = !refresh_request_n_in && req_d_reg;
    assign col_req  = !read_access_strobe_n || !write_access_strobe_n;
    assign end_edge = ale_rise || rd_rise || wr_rise;

    always_comb begin
        state_next     = state_reg;
        latch_next     = latch_reg;
        row_cnt_next   = row_cnt_reg;
        ras_cnt_next   = ras_cnt_reg;
        pend_next      = pend_reg;
        drive_req_next = drive_req_reg;
        wait_next      = wait_reg;
        addr_next      = addr_reg;
        ras_next       = ras_reg;
        cas_next       = cas_reg;
        timer_restart  = 1'b0;

        // transparent latch while the strobe is high, frozen on its fall
        if (addr_latch_en) begin
            latch_next.row_addr_in   = row_addr_in;
            latch_next.col_addr_in   = col_addr_in;
            latch_next.chip_select_n = chip_select_n;
            latch_next.bank_select   = bank_select;
        end

        // refresh request: outside edge or own timer; set beats completion
        if (req_fall) begin
            pend_next     = 1'b1;
            timer_restart = 1'b1;
        end
        if (timer_expired && !pend_reg) begin
            pend_next      = 1'b1;
            drive_req_next = 1'b1;
            timer_restart  = 1'b1;
        end

        unique case (state_reg)
            DRC_IDLE: begin
                ras_next = 2'b11;
                cas_next = 1'b1;
                // a refresh already pending wins; a latch fall in the same cycle is dropped
                if (pend_reg) begin
                    state_next = DRC_REF_ADDR;
                    addr_next  = row_cnt_reg;
                end else if (ale_fall && !chip_select_n) begin
                    state_next = DRC_ROW;
                    addr_next  = latch_reg.row_addr_in;
                    ras_next   = latch_reg.bank_select ?
                                 2'b01 : 2'b10;
                    wait_next  = straps.wait_timing_strap;
                end
            end
            DRC_ROW: begin
                wait_next = 1'b0;
                if (end_edge) begin
                    state_next = DRC_IDLE;
                    ras_next   = 2'b11;
                end else if (col_req) begin
                    state_next = DRC_COL;
                    addr_next  = latch_reg.col_addr_in;
                    cas_next   = 1'b0;
                end
            end
            DRC_COL: begin
                if (end_edge) begin
                    state_next = DRC_IDLE;
                    ras_next   = 2'b11;
                    cas_next   = 1'b1;
                end
            end
            DRC_REF_ADDR: begin
                // address is out now, so the request line may be let go
                drive_req_next = 1'b0;
                state_next     = DRC_REF_RAS;
                ras_next       = 2'b00;
                ras_cnt_next   = cfg.ras_cycles;
                wait_next      = straps.wait_timing_strap;
            end
            DRC_REF_RAS: begin
                wait_next = 1'b0;
                if (ras_cnt_reg == 3'd1) begin
                    state_next   = DRC_IDLE;
                    ras_next     = 2'b11;
                    row_cnt_next = row_cnt_reg + 8'd1;
                    if (!(req_fall || (timer_expired && !pend_reg))) begin
                        pend_next = 1'b0;
                    end
                end else begin
                    ras_cnt_next = ras_cnt_reg - 3'd1;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg     <= DRC_IDLE;
            latch_reg     <= '0;
            row_cnt_reg   <= `DRC_ROW_RESET;
            ras_cnt_reg   <= 3'd0;
            pend_reg      <= 1'b0;
            drive_req_reg <= 1'b0;
            wait_reg      <= 1'b0;
            addr_reg      <= 8'h00;
            ras_reg       <= 2'b11;
            cas_reg       <= 1'b1;
            ale_d_reg     <= 1'b0;
            rd_d_reg      <= 1'b1;
            wr_d_reg      <= 1'b1;
            req_d_reg     <= 1'b1;
        end else begin
            state_reg     <= state_next;
            latch_reg     <= latch_next;
            row_cnt_reg   <= row_cnt_next;
            ras_cnt_reg   <= ras_cnt_next;
            pend_reg      <= pend_next;
            drive_req_reg <= drive_req_next;
            wait_reg      <= wait_next;
            addr_reg      <= addr_next;
            ras_reg       <= ras_next;
            cas_reg       <= cas_next;
            ale_d_reg     <= addr_latch_en;
            rd_d_reg      <= read_access_strobe_n;
            wr_d_reg      <= write_access_strobe_n;
            req_d_reg     <= refresh_request_n_in;
        end
    end

    assign mem_addr_out          = addr_reg;
    assign row_strobe_bank_n     = ras_reg;
    assign col_strobe_n          = cas_reg;
    assign refresh_request_n_out = 1'b0;
    assign refresh_request_n_oe  = drive_req_reg;
    // ready drops for the wait state, and for refresh in cycle-steal mode
    assign ready = !wait_reg &&
                   !((cfg.mode == DRC_CYCLE_STEAL) &&
                     (pend_reg || state_reg == DRC_REF_ADDR ||
                      state_reg == DRC_REF_RAS));

endmodule // drc_controller
`default_nettype wire

// ===== bench/drc_refresh_partner.sv
// outside refresh requester sharing the open-drain refresh line
// assumes a pull-up on the line; bench pulses pulse_req for one clock
`timescale 1ns/1ns
`default_nettype none
module drc_refresh_partner (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       pulse_req,
    input  wire logic [3:0] hold_cyc,
    input  wire logic       dev_out,
    input  wire logic       dev_oe,
    output logic            line_n
);
    logic [3:0] cnt_reg;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst)
            cnt_reg <= 4'h0;
        else if (pulse_req)
            cnt_reg <= hold_cyc;
        else if (cnt_reg != 4'h0)
            cnt_reg <= cnt_reg - 4'h1;
    end
    // wired and: either party pulling low wins, else the pull-up
    assign line_n = ((dev_oe && !dev_out) || cnt_reg != 4'h0) ? 1'b0 : 1'b1;
endmodule // drc_refresh_partner
`default_nettype wire

// ===== bench/drc_controller_assertions.sv
// pin-level checks of the dram controller: strobes, mux, refresh line
// assumes straps only change while nrst is low
`timescale 1ns/1ns
`default_nettype none
module drc_controller_assertions
    import drc_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic [7:0]  row_addr_in,
    input wire logic        addr_latch_en,
    input wire logic        chip_select_n,
    input wire logic        bank_select,
    input wire logic        read_access_strobe_n,
    input wire logic        write_access_strobe_n,
    input wire logic        refresh_request_n_in,
    input wire logic        refresh_request_n_oe,
    input wire drc_straps_t straps,
    input wire logic [7:0]  mem_addr_out,
    input wire logic [1:0]  row_strobe_bank_n,
    input wire logic        col_strobe_n,
    input wire logic        ready
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    logic       one_bank;
    logic [1:0] rs_prev_reg, rs_prev_next;
    logic [7:0] row_reg, row_next;
    logic       ref_start;
    assign one_bank = row_strobe_bank_n == 2'h1 || row_strobe_bank_n == 2'h2;
    assign ref_start = row_strobe_bank_n == 2'h0 && rs_prev_reg != 2'h0;
    // shadow of the refresh row, bumped as each refresh ends
    always_comb begin
        rs_prev_next = row_strobe_bank_n;
        row_next = row_reg;
        if (rs_prev_reg == 2'h0 && row_strobe_bank_n != 2'h0)
            row_next = row_reg + 8'h01;
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rs_prev_reg <= 2'h3;
            row_reg     <= 8'h00;
        end else begin
            rs_prev_reg <= rs_prev_next;
            row_reg     <= row_next;
        end
    end
    a_row_phase: assert property (
        $fell(addr_latch_en) && !chip_select_n && row_strobe_bank_n == 2'h3
        |=> row_strobe_bank_n inside {2'h0, 2'h3} ||
        (mem_addr_out == $past(row_addr_in, 2) && row_strobe_bank_n ==
        ($past(bank_select, 2) ? 2'h1 : 2'h2)))
        else $error("row phase address or bank strobe wrong");
    a_no_select: assert property (
        $fell(addr_latch_en) && chip_select_n && row_strobe_bank_n == 2'h3
        |=> !one_bank) else $error("access started while deselected");
    a_col_phase: assert property (
        one_bank && !addr_latch_en &&
        (!read_access_strobe_n || !write_access_strobe_n) |=> !col_strobe_n)
        else $error("column strobe missing");
    a_col_alone: assert property (
        !col_strobe_n |-> one_bank) else $error("column strobe outside access");
    a_access_end: assert property (
        one_bank && ($rose(addr_latch_en) || $rose(read_access_strobe_n) ||
        $rose(write_access_strobe_n)) |=> row_strobe_bank_n == 2'h3 &&
        col_strobe_n) else $error("access not ended");
    a_ref_short: assert property (
        ref_start && !straps.wait_timing_strap |-> (row_strobe_bank_n == 2'h0)[*3]
        ##1 row_strobe_bank_n == 2'h3) else $error("refresh strobe length wrong");
    a_ref_long: assert property (
        ref_start && straps.wait_timing_strap |-> (row_strobe_bank_n == 2'h0)[*4]
        ##1 row_strobe_bank_n == 2'h3) else $error("long refresh length wrong");
    a_ref_addr: assert property (
        ref_start |-> mem_addr_out == row_reg) else $error("refresh row wrong");
    a_req_hold: assert property (
        $rose(refresh_request_n_oe) |=> refresh_request_n_oe ##1
        (!refresh_request_n_oe && row_strobe_bank_n == 2'h0))
        else $error("refresh line release wrong");
    a_ext_start: assert property (
        $fell(refresh_request_n_in) && !refresh_request_n_oe &&
        row_strobe_bank_n == 2'h3 |-> ##[1:6] row_strobe_bank_n == 2'h0)
        else $error("outside refresh not started");
    a_steal_ready: assert property (
        straps.rate_strap_1 && straps.rate_strap_0 && row_strobe_bank_n == 2'h0
        |-> !ready) else $error("ready high during stolen refresh");
    a_wait_ready: assert property (
        rs_prev_reg == 2'h3 && one_bank && straps.wait_timing_strap
        |-> !ready ##1 ready) else $error("wait state wrong");
endmodule // drc_controller_assertions
bind drc_controller drc_controller_assertions u_chk (
    .sys_clk(sys_clk), .nrst(nrst), .row_addr_in(row_addr_in),
    .addr_latch_en(addr_latch_en), .chip_select_n(chip_select_n),
    .bank_select(bank_select), .read_access_strobe_n(read_access_strobe_n),
    .write_access_strobe_n(write_access_strobe_n), .straps(straps),
    .refresh_request_n_in(refresh_request_n_in), .ready(ready),
    .refresh_request_n_oe(refresh_request_n_oe), .mem_addr_out(mem_addr_out),
    .row_strobe_bank_n(row_strobe_bank_n), .col_strobe_n(col_strobe_n));
`default_nettype wire

// ===== bench/drc_controller_tb.sv
// self-checking bench: accesses, timer and outside refresh per strap set
// assumes the partner model drives the shared refresh line
`timescale 1ns/1ns
`default_nettype none
module drc_controller_tb;
    import drc_pkg::*;
    logic        sys_clk = 1'b0, nrst = 1'b0, addr_latch_en = 1'b0;
    logic        chip_select_n = 1'b1, bank_select = 1'b0, pulse_req = 1'b0;
    logic        read_access_strobe_n = 1'b1, write_access_strobe_n = 1'b1;
    logic [7:0]  row_addr_in = 8'h00, col_addr_in = 8'h00, row_exp;
    logic        line_n, dev_out, dev_oe, col_strobe_n, ready;
    logic [7:0]  mem_addr_out;
    logic [1:0]  row_strobe_bank_n;
    drc_straps_t straps = '0;
    int          n_fail = 0, samples_checked = 0, cyc = 0, t_ref, t0;
    logic [2:0]  strap_tab [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
    int          iv_tab [5] = '{375, 750, 0, 0, 375};
    drc_controller uut (.sys_clk(sys_clk), .nrst(nrst),
        .row_addr_in(row_addr_in), .col_addr_in(col_addr_in),
        .addr_latch_en(addr_latch_en), .chip_select_n(chip_select_n),
        .bank_select(bank_select), .read_access_strobe_n(read_access_strobe_n),
        .write_access_strobe_n(write_access_strobe_n), .straps(straps),
        .refresh_request_n_in(line_n), .refresh_request_n_out(dev_out),
        .refresh_request_n_oe(dev_oe), .mem_addr_out(mem_addr_out),
        .row_strobe_bank_n(row_strobe_bank_n), .col_strobe_n(col_strobe_n),
        .ready(ready));
    drc_refresh_partner u_far (.sys_clk(sys_clk), .nrst(nrst),
        .pulse_req(pulse_req), .hold_cyc(4'h2 + 4'(cyc[1:0])),
        .dev_out(dev_out), .dev_oe(dev_oe), .line_n(line_n));
    always #20 sys_clk = ~sys_clk;
    task automatic final_report;
        if (n_fail == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // a hung refresh wait must still reach the verdict
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            final_report;
        end
    end
    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (e !== g) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic access(input logic [7:0] r, c, input logic b, wr,
                          input logic [1:0] er);
        row_addr_in = r;
        col_addr_in = c;
        bank_select = b;
        addr_latch_en = 1'b1;
        tick;
        addr_latch_en = 1'b0;
        chip_select_n = 1'b0;
        tick;
        // wait state stands only in the first row cycle
        chk("ready", {7'h00, ~straps.wait_timing_strap}, {7'h00, ready});
        tick;
        chk("row strobes", {6'h00, er}, {6'h00, row_strobe_bank_n});
        chk("row address", r, mem_addr_out);
        chk("wait over", 8'h01, {7'h00, ready});
        if (wr)
            write_access_strobe_n = 1'b0;
        else
            read_access_strobe_n = 1'b0;
        tick;
        tick;
        chk("col strobe", 8'h00, {7'h00, col_strobe_n});
        chk("col address", c, mem_addr_out);
        if (wr)
            addr_latch_en = 1'b1;
        else
            read_access_strobe_n = 1'b1;
        tick;
        tick;
        chk("end strobes", 8'h07, {5'h00, col_strobe_n, row_strobe_bank_n});
        write_access_strobe_n = 1'b1;
        addr_latch_en = 1'b0;
        chip_select_n = 1'b1;
        tick;
        tick;
        chk("deselected", 8'h03, {6'h00, row_strobe_bank_n});
    endtask
    task automatic refresh_check(input int len);
        int n;
        n = 0;
        while (row_strobe_bank_n !== 2'h0 && n < 900) begin
            tick;
            n++;
        end
        t_ref = cyc;
        chk("refresh row", row_exp, mem_addr_out);
        n = 0;
        while (row_strobe_bank_n === 2'h0 && n < 9) begin
            tick;
            n++;
        end
        chk("refresh length", 8'(len), 8'(n));
        row_exp++;
    endtask
    task automatic pulse;
        pulse_req = 1'b1;
        tick;
        pulse_req = 1'b0;
    endtask
    initial begin
        for (int k = 0; k < 5; k++) begin
            nrst = 1'b0;
            straps = drc_straps_t'(strap_tab[k]);
            repeat (5) tick;
            nrst = 1'b1;
            row_exp = 8'h00;
            chk("reset pins", 8'h17, {3'h0, ready, dev_oe, col_strobe_n, row_strobe_bank_n});
            chk("reset address", 8'h00, mem_addr_out);
            refresh_check(straps.wait_timing_strap ? 4 : 3);
            t0 = t_ref;
            access(8'h5a, 8'ha5, 1'b0, 1'b0, 2'h2);
            access(8'hc3, 8'h3c, 1'b1, 1'b1, 2'h1);
            refresh_check(straps.wait_timing_strap ? 4 : 3);
            if (iv_tab[k] != 0)
                chk("interval", 8'h01, {7'h00, (t_ref - t0 - iv_tab[k]) inside {[-2:2]}});
            repeat (100) tick;
            pulse;
            refresh_check(straps.wait_timing_strap ? 4 : 3);
            t0 = t_ref;
            refresh_check(straps.wait_timing_strap ? 4 : 3);
            if (iv_tab[k] != 0)
                chk("timer restart", 8'h01, {7'h00, (t_ref - t0 - iv_tab[k]) inside {[-2:2]}});
            if (k == 0) begin
                repeat (254) begin
                    pulse;
                    refresh_check(3);
                end
            end
        end
        final_report;
    end
endmodule // drc_controller_tb
`default_nettype wire
